// ---- rtl/lcis_line_clock_irq.sv ----
// Line clock interrupt source with its bus interrupt sequencer and an AXI4-Lite slave.
// Assumes bus lines synchronous to aclk; raw_line_tick is asynchronous.
//
// Overview of operation
// - Tick sets clock flag; flag and enable request.
// - Word write clears flag, loads enable bit.
// - Read returns clock flag and enable bits.
// - Vector phase drives data bit six.
// - Initialize sets flag, clears enable.
// - Request line only from idle sequencer.
// - Own grant sets first flag, raises SACK.
// - Delayed grant, blocked downstream by SACK.
// - Second flag on grant, busy, SSYN gone.
// - Both flags: busy, INTR, vector phase.
// - Acknowledge clears both flags, clock flag.
// - No request holds both flags clear.
// - Foreign grant passes on after delay.
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "lcis_map.svh"
module lcis_line_clock_irq #(
   parameter int GRANT_DLY = `LCIS_GRANT_DLY_CYC
) (
   // Clock and reset (reset is bus initialize)
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // Line tick from the supply
   input  wire logic                  raw_line_tick,
   // System bus lines
   input  wire lcis_pkg::lcis_bus_in_s bus_in,
   output lcis_pkg::lcis_bus_out_s    bus_out,
   // AXI4-Lite write address
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic [2:0]            s_axi_awprot,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   // AXI4-Lite write data and response
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic [2:0]            s_axi_arprot,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Interrupt to the local processor
   output logic                       irq
);
   import lcis_pkg::*;

   // Line tick and grant timing
   logic shaped_line_tick;
   logic grant_pass_in;
   logic bg6_dly;

   lcis_sync_edge u_tick_sync (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .din        (raw_line_tick),
      .rise_pulse (shaped_line_tick)
   );

   lcis_grant_delay #(
      .DLY (GRANT_DLY)
   ) u_grant_dly (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     (grant_pass_in),
      .dout    (bg6_dly)
   );

   // Clock flag, enable and sequencer flags
   logic      clk_flag_q;
   logic      clk_flag_d;
   logic      irq_en_q;
   logic      irq_en_d;
   logic      seq_flag_first_q;
   logic      seq_flag_first_d;
   logic      seq_flag_second_q;
   logic      seq_flag_second_d;
   logic      tick_irq_request;
   logic      irq_vector_phase;
   logic      irq_done_ack;
   logic      tick_reg_write;
   logic      sack_phase;
   logic      first_set;
   logic      second_set;
   lcis_seq_e seq_phase;

   // AXI slave state
   logic [7:0]            aw_addr_q;
   logic                  aw_held_q;
   logic [31:0]           w_data_q;
   logic [3:0]            w_strb_q;
   logic                  w_held_q;
   logic                  bvalid_q;
   logic [1:0]            bresp_q;
   logic                  rvalid_q;
   logic [31:0]           rdata_q;
   logic [1:0]            rresp_q;
   logic [`LCIS_EV_W-1:0] ev_stat_q;
   logic [`LCIS_EV_W-1:0] ev_stat_d;
   logic [`LCIS_EV_W-1:0] ev_mask_q;
   logic [`LCIS_EV_W-1:0] ev_set;

   // Decode
   logic        aw_hs;
   logic        w_hs;
   logic        ar_hs;
   logic        wr_go;
   logic        wr_hit_csr;
   logic        wr_hit_mask;
   logic        wr_hit_any;
   logic        rd_hit_csr;
   logic        rd_hit_stat;
   logic        rd_hit_mask;
   logic        rd_hit_seq;
   logic        rd_hit_any;
   logic        stat_read_clr;
   logic [31:0] rd_mux;

   assign aw_hs = s_axi_awvalid & s_axi_awready;
   assign w_hs  = s_axi_wvalid & s_axi_wready;
   assign ar_hs = s_axi_arvalid & s_axi_arready;
   assign wr_go = aw_held_q & w_held_q & ~bvalid_q;

   assign wr_hit_csr  = aw_addr_q[7:2] == 6'(`LCIS_OFF_TICK_CSR >> 2);
   assign wr_hit_mask = aw_addr_q[7:2] == 6'(`LCIS_OFF_IRQ_MASK >> 2);
   assign wr_hit_any  = wr_hit_csr | wr_hit_mask
                      | (aw_addr_q[7:2] == 6'(`LCIS_OFF_IRQ_STAT >> 2))
                      | (aw_addr_q[7:2] == 6'(`LCIS_OFF_SEQ_STAT >> 2));
   assign rd_hit_csr  = s_axi_araddr[7:2] == 6'(`LCIS_OFF_TICK_CSR >> 2);
   assign rd_hit_stat = s_axi_araddr[7:2] == 6'(`LCIS_OFF_IRQ_STAT >> 2);
   assign rd_hit_mask = s_axi_araddr[7:2] == 6'(`LCIS_OFF_IRQ_MASK >> 2);
   assign rd_hit_seq  = s_axi_araddr[7:2] == 6'(`LCIS_OFF_SEQ_STAT >> 2);
   assign rd_hit_any  = rd_hit_csr | rd_hit_stat | rd_hit_mask | rd_hit_seq;

   // Upper byte alone stands for an odd-address byte write and is ignored
   assign tick_reg_write = wr_go & wr_hit_csr & w_strb_q[0];
   assign stat_read_clr  = ar_hs & rd_hit_stat;

   assign rd_mux = rd_hit_csr  ? {24'h00_0000, clk_flag_q, irq_en_q, 6'h00}
                 : rd_hit_stat ? {30'h0000_0000, ev_stat_q}
                 : rd_hit_mask ? {30'h0000_0000, ev_mask_q}
                 : rd_hit_seq  ? {28'h000_0000, tick_irq_request, seq_phase == SEQ_VECTOR,
                                  seq_flag_second_q, seq_flag_first_q}
                 : 32'h0000_0000;

   // Request and sequencer conditions
   assign tick_irq_request = clk_flag_q & irq_en_q;
   assign sack_phase       = seq_flag_first_q & ~seq_flag_second_q;
   assign irq_vector_phase = seq_flag_first_q & seq_flag_second_q;
   assign irq_done_ack     = bus_in.ssyn & irq_vector_phase;
   assign first_set        = bus_in.bg6 & bus_out.br6;
   // Second flag waits for the adapter to let go of grant and busy
   assign second_set       = sack_phase & ~bus_in.bg6 & ~bus_in.bbsy
                           & ~bus_in.ssyn;

   always_comb begin
      unique case ({seq_flag_second_q, seq_flag_first_q})
         2'b01:   seq_phase = SEQ_SELECT;
         2'b11:   seq_phase = SEQ_VECTOR;
         default: seq_phase = SEQ_IDLE;
      endcase
   end

   // A tick in the clearing cycle still sets the flag
   assign clk_flag_d = shaped_line_tick ? 1'b1
                     : (tick_reg_write | irq_done_ack) ? 1'b0
                     : clk_flag_q;
   assign irq_en_d   = tick_reg_write ? w_data_q[`LCIS_BIT_IRQ_EN] : irq_en_q;

   assign seq_flag_first_d  = (~tick_irq_request | irq_done_ack) ? 1'b0
                            : (seq_flag_first_q | first_set);
   assign seq_flag_second_d = (~tick_irq_request | irq_done_ack) ? 1'b0
                            : (seq_flag_second_q | second_set);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_flag_q        <= `LCIS_RST_CLK_FLAG;
         irq_en_q          <= `LCIS_RST_IRQ_EN;
         seq_flag_first_q  <= 1'b0;
         seq_flag_second_q <= 1'b0;
      end else begin
         clk_flag_q        <= clk_flag_d;
         irq_en_q          <= irq_en_d;
         seq_flag_first_q  <= seq_flag_first_d;
         seq_flag_second_q <= seq_flag_second_d;
      end
   end

   // Bus outputs
   assign bus_out.br6     = tick_irq_request & ~seq_flag_first_q & ~seq_flag_second_q;
   assign bus_out.sack    = sack_phase;
   assign bus_out.bbsy_o  = 1'b1;
   assign bus_out.bbsy_oe = irq_vector_phase;
   assign bus_out.intr    = irq_vector_phase;
   assign bus_out.d06_o   = 1'b1;
   assign bus_out.d06_oe  = irq_vector_phase;
   // Own grant never enters the delay line: it would outlive a short SACK phase
   assign grant_pass_in = bus_in.bg6 & ~bus_out.br6 & ~seq_flag_first_q;
   // Own request or SACK stops the grant; the delay lets SACK win the race
   assign bus_out.grant_chain_out = bg6_dly & ~bus_out.br6 & ~seq_flag_first_q
                                  & ~bus_out.sack;

   // Event status, read clears, set wins
   assign ev_set = {irq_done_ack, shaped_line_tick};
   assign ev_stat_d = (stat_read_clr ? `LCIS_RST_EV : ev_stat_q) | ev_set;
   assign irq = |(ev_stat_q & ev_mask_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev_stat_q <= `LCIS_RST_EV;
         ev_mask_q <= `LCIS_RST_EV;
      end else begin
         ev_stat_q <= ev_stat_d;
         if (wr_go & wr_hit_mask & w_strb_q[0]) begin
            ev_mask_q <= w_data_q[`LCIS_EV_W-1:0];
         end
      end
   end

   // AXI write channel
   assign s_axi_awready = ~aw_held_q & ~bvalid_q;
   assign s_axi_wready  = ~w_held_q & ~bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `LCIS_RESP_OKAY;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
      end else begin
         if (aw_hs) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_hs) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_hit_any ? `LCIS_RESP_OKAY : `LCIS_RESP_SLVERR;
         end else if (bvalid_q & s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // AXI read channel
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `LCIS_RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_mux;
         rresp_q  <= rd_hit_any ? `LCIS_RESP_OKAY : `LCIS_RESP_SLVERR;
      end else if (rvalid_q & s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence own_grant_s;
      bus_out.br6 && bus_in.bg6;
   endsequence

   sequence select_s;
      seq_flag_first_q && !seq_flag_second_q && bus_out.sack && !bus_out.br6;
   endsequence

   sequence release_s;
      bus_out.sack && !bus_in.bg6 && !bus_in.bbsy && !bus_in.ssyn && tick_irq_request
      && !tick_reg_write;
   endsequence

   tick_request_a: assert property (shaped_line_tick && irq_en_q && !tick_reg_write
                                    |=> tick_irq_request)
      else $error("tick with enable did not raise the request");

   csr_write_a: assert property (tick_reg_write && !shaped_line_tick |=>
                                 !clk_flag_q && irq_en_q == $past(w_data_q[`LCIS_BIT_IRQ_EN]))
      else $error("register write did not clear flag or load enable");

   odd_byte_a: assert property (wr_go && wr_hit_csr && !w_strb_q[0] |=>
                                irq_en_q == $past(irq_en_q))
      else $error("odd byte write changed the enable");

   csr_read_a: assert property (ar_hs && rd_hit_csr |=>
                                s_axi_rvalid && s_axi_rdata[7:6] == $past({clk_flag_q, irq_en_q}))
      else $error("register read returned wrong flags");

   init_state_a: assert property ($rose(aresetn) |-> clk_flag_q && !irq_en_q
                                  && !seq_flag_first_q && !seq_flag_second_q)
      else $error("initialize left wrong flag values");

   idle_request_a: assert property (bus_out.br6 |-> seq_phase == SEQ_IDLE
                                    && tick_irq_request)
      else $error("request line raised outside idle");

   grant_take_a: assert property (own_grant_s |=> select_s)
      else $error("own grant did not reach selection");

   chain_block_a: assert property (bus_out.sack |-> !bus_out.grant_chain_out)
      else $error("grant passed downstream during selection");

   vector_enter_a: assert property (release_s |=> bus_out.intr && bus_out.bbsy_oe
                                    && bus_out.d06_oe && !bus_out.sack)
      else $error("release did not enter the vector phase");

   second_cause_a: assert property ($rose(seq_flag_second_q) |->
                                    $past(sack_phase && !bus_in.bg6 && !bus_in.bbsy))
      else $error("second flag set without bus release");

   ack_clear_a: assert property (irq_done_ack |=> seq_phase == SEQ_IDLE
                                 && !bus_out.intr && !bus_out.bbsy_oe && !bus_out.br6)
      else $error("acknowledge did not end the transfer");

   idle_hold_a: assert property (!tick_irq_request ##1 !tick_irq_request |->
                                 !seq_flag_first_q && !seq_flag_second_q)
      else $error("sequencer flags set without request");

   foreign_pass_a: assert property (bus_in.bg6 && !tick_irq_request &&
                                    seq_phase == SEQ_IDLE |-> ##GRANT_DLY
                                    (bus_out.grant_chain_out || tick_irq_request))
      else $error("foreign grant not passed on");

   tick_pulse_a: assert property (shaped_line_tick |=> !shaped_line_tick)
      else $error("line tick pulse longer than one cycle");

   grant_delay_a: assert property ($rose(bg6_dly) |-> $past(bus_in.bg6, GRANT_DLY))
      else $error("grant delay count wrong");

   irq_level_a: assert property (|(ev_stat_q & ev_mask_q) == irq)
      else $error("interrupt output disagrees with status and mask");

endmodule // lcis_line_clock_irq

// ---- common/lcis_map.svh ----
// Address map, field positions, reset values and timing counts of the line clock block.
// Included by the design files; holds definitions only.
`ifndef LCIS_MAP_SVH
`define LCIS_MAP_SVH

// Register byte offsets on the AXI4-Lite slave
`define LCIS_OFF_TICK_CSR    8'h00
`define LCIS_OFF_IRQ_STAT    8'h04
`define LCIS_OFF_IRQ_MASK    8'h08
`define LCIS_OFF_SEQ_STAT    8'h0C

// Field positions
`define LCIS_BIT_CLK_FLAG    7
`define LCIS_BIT_IRQ_EN      6
`define LCIS_BIT_VECTOR      6
`define LCIS_EV_TICK         0
`define LCIS_EV_DONE         1
`define LCIS_EV_W            2

// Reset values
`define LCIS_RST_CLK_FLAG    1'b1
`define LCIS_RST_IRQ_EN      1'b0
`define LCIS_RST_EV          2'b00

// Bus responses
`define LCIS_RESP_OKAY       2'b00
`define LCIS_RESP_SLVERR     2'b10

// Timing: grant hold-back time and its cycle count at 40 MHz
`define LCIS_CLK_PERIOD_NS   25
`define LCIS_GRANT_DLY_NS    100
`define LCIS_GRANT_DLY_CYC   ((`LCIS_GRANT_DLY_NS + `LCIS_CLK_PERIOD_NS - 1) / `LCIS_CLK_PERIOD_NS)

`endif

// ---- common/lcis_pkg.sv ----
// Types shared by the line clock interrupt sequencer files.
// Pure declarations; no logic.
package lcis_pkg;

   // System bus lines seen by the block
   typedef struct packed {
      logic bg6;
      logic bbsy;
      logic ssyn;
   } lcis_bus_in_s;

   // System bus lines driven by the block
   typedef struct packed {
      logic br6;
      logic sack;
      logic bbsy_o;
      logic bbsy_oe;
      logic intr;
      logic d06_o;
      logic d06_oe;
      logic grant_chain_out;
   } lcis_bus_out_s;

   // Sequencer phase as formed by the two flags
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_SELECT,
      SEQ_VECTOR
   } lcis_seq_e;

endpackage

// ---- rtl/lcis_sync_edge.sv ----
// Two-stage synchroniser with rising edge detect, one-cycle pulse out.
// Assumes an asynchronous slow level on din.
`timescale 1ns/1ps
module lcis_sync_edge (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Level in, pulse out
   input  wire logic din,
   output logic      rise_pulse
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign rise_pulse = sync_q & ~last_q;
endmodule // lcis_sync_edge

// ---- rtl/lcis_grant_delay.sv ----
// Fixed delay line for the incoming bus grant.
// Assumes the grant is synchronous to aclk; DLY must be at least one.
`timescale 1ns/1ps
module lcis_grant_delay #(
   parameter int DLY = 4
) (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Grant in, delayed grant out
   input  wire logic din,
   output logic      dout
);
   logic [DLY-1:0] pipe_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pipe_q <= '0;
      end else if (DLY == 1) begin
         pipe_q <= DLY'(din);
      end else begin
         pipe_q <= {pipe_q[DLY-2:0], din};
      end
   end

   assign dout = pipe_q[DLY-1];
endmodule // lcis_grant_delay

// ---- tb/lcis_bca_model.sv ----
// Behavioural bus channel adapter and CPU facing the line clock block.
// Assumes the block's bus lines are synchronous to aclk; bus busy is a wired line.
`timescale 1ns/1ps
module lcis_bca_model (
   // Clock and reset
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   // Scenario controls
   input  wire logic                    hold,
   input  wire logic                    foreign,
   input  wire logic [3:0]              dly,
   // Bus lines
   input  wire lcis_pkg::lcis_bus_out_s bus_out,
   output lcis_pkg::lcis_bus_in_s       bus_in
);
   import lcis_pkg::*;
   logic       bg_q;
   logic       busy_q;
   logic       ssyn_q;
   logic [3:0] cnt_q;
   wire        wait_w = (bus_out.br6 && !hold && !bg_q) || (bus_out.intr && !ssyn_q);
   // Foreign grant models a request from another device
   assign bus_in.bg6  = bg_q | foreign;
   // Wired busy: CPU holds it until SACK, then the block drives it in the vector phase
   assign bus_in.bbsy = busy_q | (bus_out.bbsy_oe & bus_out.bbsy_o);
   assign bus_in.ssyn = ssyn_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bg_q   <= 1'b0;
         busy_q <= 1'b1;
         ssyn_q <= 1'b0;
         cnt_q  <= 4'h0;
      end else begin
         cnt_q <= wait_w ? cnt_q + 4'h1 : 4'h0;
         if (bus_out.sack) begin
            bg_q   <= 1'b0;
            busy_q <= 1'b0;
         end else if (bus_out.br6 && !hold && cnt_q >= dly) begin
            bg_q <= 1'b1;
         end
         if (bus_out.intr && cnt_q >= dly) begin
            ssyn_q <= 1'b1;
         end else if (!bus_out.intr && ssyn_q) begin
            ssyn_q <= 1'b0;
            busy_q <= 1'b1;
         end
      end
   end
endmodule // lcis_bca_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the line clock interrupt sequencer.
// Assumes the adapter model and the design files are compiled first.
`timescale 1ns/1ps
`include "lcis_map.svh"
module tb_top;
   import lcis_pkg::*;
   localparam int GD = 4;
   logic          aclk, aresetn, raw_line_tick, hold, foreign, in_seq, leak;
   logic [3:0]    dly, s_axi_wstrb;
   logic [7:0]    s_axi_awaddr, s_axi_araddr;
   logic [2:0]    s_axi_awprot, s_axi_arprot;
   logic          s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic          irq;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   logic [31:0]   s_axi_wdata, s_axi_rdata, rd_q;
   lcis_bus_in_s  bus_in;
   lcis_bus_out_s bus_out;
   int            n_mismatch, num_checks;

   lcis_line_clock_irq #(.GRANT_DLY(GD)) u_dut (
      .aclk, .aresetn, .raw_line_tick, .bus_in, .bus_out, .irq,
      .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   lcis_bca_model u_bca (.aclk, .aresetn, .hold, .foreign, .dly, .bus_out, .bus_in);

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   // Any delayed grant leaking out during our own transfer
   always @(negedge aclk) if (in_seq && bus_out.grant_chain_out !== 1'b0) leak = 1'b1;

   task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Ready is sampled at the falling edge, so the handshake edge is the next rising one
   task automatic wck(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er = `LCIS_RESP_OKAY);
      int   n;
      logic aw_t, w_t, b_t;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      n = 0;
      b_t = 1'b0;
      while (!b_t && n < 50) begin
         @(negedge aclk);
         aw_t = s_axi_awvalid & s_axi_awready;
         w_t = s_axi_wvalid & s_axi_wready;
         b_t = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
         n++;
      end
      ck("bresp", 32'(er), 32'(r));
   endtask

   task automatic rck(input string nm, input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
      int   n;
      logic ar_t, r_t;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      n = 0;
      r_t = 1'b0;
      while (!r_t && n < 50) begin
         @(negedge aclk);
         ar_t = s_axi_arvalid & s_axi_arready;
         r_t = s_axi_rvalid;
         rd_q = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ar_t) s_axi_arvalid <= 1'b0;
         n++;
      end
      ck(nm, e, rd_q);
      ck({nm, "_resp"}, 32'(er), 32'(r));
   endtask

   // Waits at falling edges for one bus output to reach a level
   task automatic wt(input string nm, input int k, input logic v);
      int   n;
      logic s;
      n = 0;
      s = ~v;
      while (s !== v && n < 200) begin
         @(negedge aclk);
         s = k == 0 ? bus_out.br6 : k == 1 ? bus_out.sack :
             k == 2 ? bus_out.intr : bus_out.grant_chain_out;
         n++;
      end
      ck(nm, 32'(v), 32'(s));
   endtask

   // Returns before the request can rise, so the waits that follow still see it
   task automatic tick;
      @(posedge aclk);
      raw_line_tick <= 1'b1;
      @(posedge aclk);
      raw_line_tick <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic t_reset;
      rck("csr_init", `LCIS_OFF_TICK_CSR, 32'h80, `LCIS_RESP_OKAY);
      rck("seq_init", `LCIS_OFF_SEQ_STAT, 32'h0, `LCIS_RESP_OKAY);
      rck("unmapped", 8'h10, 32'h0, `LCIS_RESP_SLVERR);
      wck(8'h10, 32'h0, 4'hF, `LCIS_RESP_SLVERR);
      $display("test reset done");
   endtask

   task automatic t_csr;
      wck(`LCIS_OFF_TICK_CSR, 32'hC0, 4'hF);
      rck("csr_word", `LCIS_OFF_TICK_CSR, 32'h40, `LCIS_RESP_OKAY);
      wck(`LCIS_OFF_TICK_CSR, 32'h0, 4'h2);
      rck("csr_odd", `LCIS_OFF_TICK_CSR, 32'h40, `LCIS_RESP_OKAY);
      wck(`LCIS_OFF_TICK_CSR, 32'h0, 4'hF);
      rck("csr_off", `LCIS_OFF_TICK_CSR, 32'h0, `LCIS_RESP_OKAY);
      $display("test csr done");
   endtask

   task automatic t_tick;
      wck(`LCIS_OFF_IRQ_MASK, 32'h1, 4'hF);
      tick;
      rck("csr_tick", `LCIS_OFF_TICK_CSR, 32'h80, `LCIS_RESP_OKAY);
      @(negedge aclk);
      ck("irq_set", 32'h1, 32'(irq));
      ck("br6_off", 32'h0, 32'(bus_out.br6));
      rck("stat_tick", `LCIS_OFF_IRQ_STAT, 32'h1, `LCIS_RESP_OKAY);
      @(negedge aclk);
      ck("irq_clr", 32'h0, 32'(irq));
      rck("stat_clr", `LCIS_OFF_IRQ_STAT, 32'h0, `LCIS_RESP_OKAY);
      $display("test tick done");
   endtask

   task automatic t_seq(input logic [3:0] d);
      @(posedge aclk);
      dly <= d;
      wck(`LCIS_OFF_TICK_CSR, 32'h40, 4'hF);
      wck(`LCIS_OFF_IRQ_MASK, 32'h3, 4'hF);
      leak = 1'b0;
      in_seq = 1'b1;
      tick;
      wt("br6_up", 0, 1'b1);
      wt("sack_up", 1, 1'b1);
      ck("br6_drop", 32'h0, 32'(bus_out.br6));
      wt("intr_up", 2, 1'b1);
      ck("sack_drop", 32'h0, 32'(bus_out.sack));
      ck("busy_drive", 32'h3, 32'({bus_out.bbsy_oe, bus_out.bbsy_o}));
      ck("vector_bit", 32'h3, 32'({bus_out.d06_oe, bus_out.d06_o}));
      wt("intr_down", 2, 1'b0);
      ck("drive_off", 32'h0, 32'({bus_out.br6, bus_out.sack, bus_out.bbsy_oe,
         bus_out.d06_oe, bus_out.grant_chain_out}));
      ck("chain_blocked", 32'h0, 32'(leak));
      in_seq = 1'b0;
      rck("csr_done", `LCIS_OFF_TICK_CSR, 32'h40, `LCIS_RESP_OKAY);
      rck("stat_done", `LCIS_OFF_IRQ_STAT, 32'h3, `LCIS_RESP_OKAY);
      rck("seq_done", `LCIS_OFF_SEQ_STAT, 32'h0, `LCIS_RESP_OKAY);
      $display("test sequence done");
   endtask

   task automatic t_abort;
      @(posedge aclk);
      hold <= 1'b1;
      wck(`LCIS_OFF_TICK_CSR, 32'h40, 4'hF);
      tick;
      wt("br6_held", 0, 1'b1);
      wck(`LCIS_OFF_TICK_CSR, 32'h0, 4'hF);
      @(negedge aclk);
      ck("br6_abort", 32'h0, 32'(bus_out.br6));
      rck("seq_abort", `LCIS_OFF_SEQ_STAT, 32'h0, `LCIS_RESP_OKAY);
      @(posedge aclk);
      hold <= 1'b0;
      $display("test abort done");
   endtask

   task automatic t_foreign;
      @(posedge aclk);
      foreign <= 1'b1;
      repeat (GD - 1) @(posedge aclk);
      @(negedge aclk);
      ck("chain_early", 32'h0, 32'(bus_out.grant_chain_out));
      @(negedge aclk);
      ck("chain_pass", 32'h1, 32'(bus_out.grant_chain_out));
      ck("no_sack", 32'h0, 32'(bus_out.sack));
      rck("seq_foreign", `LCIS_OFF_SEQ_STAT, 32'h0, `LCIS_RESP_OKAY);
      @(posedge aclk);
      foreign <= 1'b0;
      wt("chain_drop", 3, 1'b0);
      $display("test foreign grant done");
   endtask

   initial begin
      {aresetn, raw_line_tick, hold, foreign, in_seq, leak} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, dly} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awprot, s_axi_arprot} = '0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      n_mismatch = 0;
      num_checks = 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_csr;
      t_tick;
      t_seq(4'h0);
      t_seq(4'h3);
      t_abort;
      t_foreign;
      test_done;
   end

   // Whole run needs about two hundred cycles
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      $display("MISMATCH watchdog expected finish seen timeout");
      test_done;
   end
endmodule // tb_top
